// File: src/rcb_rx_port.sv
// rcb_rx_port: receive cell-bus output port, level 1/2 cell output path.
// assumes: cell octets arrive from the receive fifo on clk_sys with valid/ready;
// the reader's port clock and read enable are asynchronous pins.
//
// Functional notes
// - width field bits 3:2 pick lanes
// - eight-bit mode drives only upper lane
// - sixteen-bit mode drives all sixteen lanes
// - size field bits 1:0 pick 52/53/54
// - 52-octet cells carry no header check
// - 53-octet cells insert one header check octet
// - 54-octet cells add check plus stuff
// - exactly configured octets per start marker
// - width setting applies to receive only
// - level 2 runs single or multi phy
// - start marker one clock on first beat
// - odd parity over each presented beat
// - bus off while enable high; rising updates
// - bit 7 picks level 3 versus 1/2
`default_nettype none
module rcb_rx_port
  import rcb_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  // control register access
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // cell octets from the receive fifo
  input  wire logic [7:0]  fifo_octet,
  input  wire logic        fifo_valid,
  output logic             fifo_ready,
  // cell bus pins
  input  wire logic        rx_port_clock,
  input  wire logic        rx_read_enable_n,
  output logic      [15:0] rx_cell_data_bus,
  output logic      [15:0] rx_cell_data_oe,
  output logic             rx_cell_start_marker,
  output logic             rx_word_parity,
  // mode status toward the rest of the port
  output logic             level12_mode,
  output logic             multi_phy_mode
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  // clock and enable pass equal depths, so an enable change made half a
  // port-clock period before a rise is already settled when that rise is seen
  logic clk_s;
  logic enb_n_s;
  rcb_sync u_sync_clk (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .rst_val  (1'b0),
    .async_in (rx_port_clock),
    .sync_out (clk_s)
  );
  // enable resets to its idle high level by inversion
  rcb_sync u_sync_enb (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .rst_val  (1'b1),
    .async_in (~rx_read_enable_n),
    .sync_out (enb_n_s)
  );
  ////////////////////////////////////////////////////////////////////////////
  // control register
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic [1:0] wid;
  logic [1:0] csize;
  // a write lands only at the mapped address and only while enabled
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (clk_en && reg_wr && reg_addr == RCB_CTRL0_ADDR) begin
      nxt_ctrl = reg_wdata;
    end
  end
  // control value; nothing runs until bit 7 and a valid width are written
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= RCB_CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end
  // read-back; unmapped addresses read zero
  always_comb begin
    if (reg_addr == RCB_CTRL0_ADDR) begin
      reg_rdata = ctrl_ff;
    end else begin
      reg_rdata = 8'h00;
    end
  end
  // field decode from the stored control value
  assign wid            = ctrl_ff[RCB_CTRL_WID_HI:RCB_CTRL_WID_LO];
  assign csize          = ctrl_ff[RCB_CTRL_SIZE_HI:RCB_CTRL_SIZE_LO];
  assign level12_mode   = ctrl_ff[RCB_CTRL_LVL_BIT];
  assign multi_phy_mode = level12_mode & ctrl_ff[RCB_CTRL_MPHY_BIT];
  ////////////////////////////////////////////////////////////////////////////
  // cell sequencer
  logic       clk_d_ff;
  logic       nxt_clk_d;
  logic       rise;
  logic       w16;
  logic       run_ok;
  logic [5:0] oct_total;
  logic [5:0] oct_per_beat;
  rcb_state_e st_ff;
  rcb_state_e nxt_st;
  logic [5:0] idx_ff;
  logic [5:0] nxt_idx;
  rcb_beat_s  beat_ff;
  rcb_beat_s  nxt_beat;
  // delayed copy of the synchronised port clock marks each rising edge
  assign nxt_clk_d = clk_en ? clk_s : clk_d_ff;
  assign rise      = clk_en & clk_s & ~clk_d_ff;
  assign w16       = (wid == RCB_WID_16);
  // unused or invalid encodings stop output
  // a 53-octet cell would leave half a word at sixteen bits,
  // so that pairing is refused rather than padded
  always_comb begin
    oct_total = RCB_OCT_52;
    run_ok    = level12_mode & (wid == RCB_WID_8 | w16);
    case (csize)
      RCB_SIZE_52: oct_total = RCB_OCT_52;
      RCB_SIZE_53: begin
        oct_total = RCB_OCT_53;
        run_ok    = run_ok & ~w16;
      end
      RCB_SIZE_54: oct_total = RCB_OCT_54;
      default:     run_ok    = 1'b0;
    endcase
    oct_per_beat = w16 ? 6'h02 : 6'h01;
  end
  // octet source for a given cell position: fifo, check octet or stuff
  function automatic logic [7:0] pick(input logic [5:0] pos, input logic [7:0] f);
    logic [7:0] v;
    v = f;
    if (csize != RCB_SIZE_52 && pos == RCB_HEC_IDX) begin
      v = RCB_HEC_DUMMY;
    end else if (csize == RCB_SIZE_54 && pos == RCB_OCT_54 - 6'h01) begin
      v = RCB_STUFF_OCT;
    end
    return v;
  endfunction
  // octet from fifo for position pos unless inserted
  function automatic logic from_fifo(input logic [5:0] pos);
    from_fifo = !((csize != RCB_SIZE_52 && pos == RCB_HEC_IDX) ||
                  (csize == RCB_SIZE_54 && pos == RCB_OCT_54 - 6'h01));
  endfunction
  // fifo needs of the beat at the current cell position
  logic       hi_ff_need;
  logic       lo_ff_need;
  logic       have;
  logic [5:0] nidx_lo;
  // a beat is emitted only on a port-clock rise with enable low, and with fifo data unless every octet of the beat is inserted
  always_comb begin
    nxt_st     = st_ff;
    nxt_idx    = idx_ff;
    nxt_beat   = beat_ff;
    nidx_lo    = idx_ff + 6'h01;
    hi_ff_need = from_fifo(idx_ff);
    lo_ff_need = w16 & from_fifo(nidx_lo);
    have       = fifo_valid | ~(hi_ff_need | lo_ff_need);
    fifo_ready = 1'b0;
    if (rise) begin
      nxt_beat.soc = 1'b0;
      // the bus goes quiet only at the first rise after the enable is seen
      // high, so a reader gives one more rise after raising it
      nxt_beat.oe  = ~enb_n_s & run_ok;
      if (!run_ok) begin
        nxt_st   = RCB_IDLE;
        nxt_idx  = 6'h00;
        nxt_beat = '0;
      end else if (!enb_n_s && have) begin
        // fifo octets are pulled one per rise; two-lane beats need the
        // low octet inserted or pre-merged, so one fifo octet per lane pair
        fifo_ready = hi_ff_need | lo_ff_need;
        nxt_beat.data[15:8] = pick(idx_ff, fifo_octet);
        nxt_beat.data[7:0]  = w16 ? pick(nidx_lo, fifo_octet) : 8'h00;
        // a cut cell resumes where it stopped; the marker waits for a cell start
        nxt_beat.soc        = (st_ff == RCB_IDLE) && (idx_ff == 6'h00);
        nxt_beat.prty       = ~(^nxt_beat.data[15:8] ^
                                (w16 ? ^nxt_beat.data[7:0] : 1'b0));
        nxt_st              = RCB_CELL;
        if (idx_ff + oct_per_beat >= oct_total) begin
          nxt_idx = 6'h00;
          nxt_st  = RCB_IDLE;
        end else begin
          nxt_idx = idx_ff + oct_per_beat;
        end
      end
    end
  end
  // sequencer registers; pins reset low with the bus released
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      clk_d_ff <= 1'b0;
      st_ff    <= RCB_IDLE;
      idx_ff   <= 6'h00;
      beat_ff  <= '0;
    end else begin
      clk_d_ff <= nxt_clk_d;
      st_ff    <= nxt_st;
      idx_ff   <= nxt_idx;
      beat_ff  <= nxt_beat;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // pin outputs; lower lane enable only in sixteen-bit mode
  assign rx_cell_data_bus     = beat_ff.data;
  assign rx_cell_data_oe      = {{8{beat_ff.oe}}, {8{beat_ff.oe & w16}}};
  assign rx_cell_start_marker = beat_ff.soc;
  assign rx_word_parity       = beat_ff.prty;
endmodule // rcb_rx_port
`default_nettype wire

// File: src/rcb_pkg.sv
// rcb_pkg: constants and carrier types for the receive cell-bus output port.
// assumes: included before every rcb module; single system clock domain.
`default_nettype none
package rcb_pkg;
  // control register location and field layout
  localparam logic [15:0] RCB_CTRL0_ADDR     = 16'h0503;
  localparam int          RCB_CTRL_LVL_BIT   = 7;
  localparam int          RCB_CTRL_MPHY_BIT  = 6;
  localparam int          RCB_CTRL_WID_HI    = 3;
  localparam int          RCB_CTRL_WID_LO    = 2;
  localparam int          RCB_CTRL_SIZE_HI   = 1;
  localparam int          RCB_CTRL_SIZE_LO   = 0;
  localparam logic [7:0]  RCB_CTRL_RESET     = 8'h00;
  // width field encodings
  localparam logic [1:0]  RCB_WID_OFF        = 2'h0;
  localparam logic [1:0]  RCB_WID_8          = 2'h1;
  localparam logic [1:0]  RCB_WID_16         = 2'h2;
  // cell size encodings
  localparam logic [1:0]  RCB_SIZE_52        = 2'h0;
  localparam logic [1:0]  RCB_SIZE_53        = 2'h1;
  localparam logic [1:0]  RCB_SIZE_54        = 2'h2;
  localparam logic [5:0]  RCB_OCT_52         = 6'h34;
  localparam logic [5:0]  RCB_OCT_53         = 6'h35;
  localparam logic [5:0]  RCB_OCT_54         = 6'h36;
  // header check octet position and filler values
  localparam logic [5:0]  RCB_HEC_IDX        = 6'h04;
  localparam logic [7:0]  RCB_HEC_DUMMY      = 8'h00;
  localparam logic [7:0]  RCB_STUFF_OCT      = 8'h00;
  // one cell-bus beat on the pins
  typedef struct packed {
    logic [15:0] data;
    logic        soc;
    logic        prty;
    logic        oe;
  } rcb_beat_s;
  typedef enum logic [1:0] {
    RCB_IDLE = 2'b00,
    RCB_CELL = 2'b01
  } rcb_state_e;
endpackage : rcb_pkg
`default_nettype wire

// File: src/rcb_sync.sv
// rcb_sync: two-stage synchroniser for pin inputs.
// assumes: async inputs; the first stage feeds only the second.
`default_nettype none
module rcb_sync (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic clk_en,
  input  wire logic rst_val,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_ff;
  logic nxt_meta;
  logic sync_ff;
  logic nxt_sync;
  // next values of the two stages
  always_comb begin
    nxt_meta = clk_en ? async_in : meta_ff;
    nxt_sync = clk_en ? meta_ff : sync_ff;
  end
  // register stages reset low; output reset level chosen per instance by inversion
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end
  assign sync_out = sync_ff ^ rst_val;
endmodule // rcb_sync
`default_nettype wire

// File: verif/rcb_reader.sv
// rcb_reader: reader-side model that clocks the port and pulls read enable low.
// assumes: the bench raises run for a burst of beats and drops it afterwards.
`default_nettype none
module rcb_reader (
  input  wire logic run,
  output logic      rx_port_clock,
  output logic      rx_read_enable_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // port clock stands low between bursts; enable low only while reading
  initial begin
    rx_port_clock = 1'b0;
    rx_read_enable_n = 1'b1;
    forever begin
      wait (run);
      rx_read_enable_n = 1'b0;
      while (run) begin
        #32 rx_port_clock = 1'b1;
        #32 rx_port_clock = 1'b0;
      end
      rx_read_enable_n = 1'b1;
      repeat (3) begin
        #32 rx_port_clock = 1'b1;
        #32 rx_port_clock = 1'b0;
      end
    end
  end
endmodule // rcb_reader
`default_nettype wire

// File: verif/rcb_rx_port_asserts.sv
// rcb_rx_port_asserts: port checks for the receive cell-bus port.
// assumes: bound into rcb_rx_port; config is rewritten only while idle.
`default_nettype none
module rcb_rx_port_asserts
  import rcb_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_rdata,
  input wire logic        fifo_valid,
  input wire logic        fifo_ready,
  input wire logic        rx_read_enable_n,
  input wire logic [15:0] rx_cell_data_bus,
  input wire logic [15:0] rx_cell_data_oe,
  input wire logic        rx_cell_start_marker,
  input wire logic        rx_word_parity,
  input wire logic        level12_mode,
  input wire logic        multi_phy_mode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic       sel_ff;
  logic [7:0] rd_ff;
  wire logic  sel = reg_addr == RCB_CTRL0_ADDR;
  wire logic  steady = sel && sel_ff && rd_ff == reg_rdata;
  // control value seen unchanged over two cycles
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n) {sel_ff, rd_ff} <= 9'h000;
    else {sel_ff, rd_ff} <= {sel, reg_rdata};
  a_phy_mode_sel: assert property (steady |-> multi_phy_mode == &reg_rdata[7:6])
    else $error("multi phy mode wrong");
  a_eight_upper_only: assert property (steady && reg_rdata[3:2] == RCB_WID_8 |->
    rx_cell_data_oe[7:0] == 8'h00) else $error("lower lane driven");
  a_sixteen_all: assert property (steady && reg_rdata[3:2] == RCB_WID_16
    && rx_cell_data_oe[15] |-> rx_cell_data_oe == 16'hffff) else $error("lanes missing");
  a_inactive_quiet: assert property (steady && (!reg_rdata[7] || reg_rdata[3:2] ==
    RCB_WID_OFF) |-> !rx_cell_start_marker && rx_cell_data_oe == 16'h0000)
    else $error("inactive port drives");
  a_parity_odd: assert property (rx_cell_data_oe[15] |->
    ^{rx_cell_data_bus & rx_cell_data_oe, rx_word_parity}) else $error("parity not odd");
  a_marker_one_beat: assert property ($rose(rx_cell_start_marker) |->
    rx_cell_start_marker[*6] ##[1:4] !rx_cell_start_marker) else $error("marker length");
  a_bus_released: assert property ($rose(rx_read_enable_n) |->
    ##[1:40] rx_cell_data_oe == 16'h0000) else $error("bus not released");
  a_pop_when_on: assert property (fifo_ready |-> fifo_valid && level12_mode)
    else $error("fifo popped while off");
  c_cell_16: cover property ($rose(rx_cell_start_marker) && reg_rdata[3:2] == RCB_WID_16);
  c_cell_53: cover property ($rose(rx_cell_start_marker) && reg_rdata[1:0] == RCB_SIZE_53);
  c_release: cover property ($fell(rx_cell_data_oe[15]));
endmodule // rcb_rx_port_asserts
bind rcb_rx_port rcb_rx_port_asserts rcb_rx_port_asserts_i (.clk_sys, .arst_n, .reg_addr,
  .reg_rdata, .fifo_valid, .fifo_ready, .rx_read_enable_n, .rx_cell_data_bus,
  .rx_cell_data_oe, .rx_cell_start_marker, .rx_word_parity, .level12_mode, .multi_phy_mode);
`default_nettype wire

// File: verif/rcb_rx_port_test.sv
// rcb_rx_port_test: bench for the receive cell-bus port with a reader model.
// assumes: fifo always has an octet; octets are random, one per falling edge.
`default_nettype none
module rcb_rx_port_test;
  import rcb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, arst_n, reg_wr, run, armed, fifo_ready, level12_mode;
  logic        clk_en, multi_phy_mode;
  logic [15:0] reg_addr, rx_cell_data_bus, rx_cell_data_oe;
  logic [7:0]  reg_wdata, reg_rdata, fifo_octet, cur;
  logic        rx_port_clock, rx_read_enable_n, rx_cell_start_marker, rx_word_parity;
  int          seed, checks, num_errors, cycles, nbeat, nsoc;
  logic [4:0]  cfg [10] = '{5'h14, 5'h15, 5'h18, 5'h1a, 5'h10, 5'h19, 5'h1c, 5'h17, 5'h04,
    5'h16};
  rcb_rx_port rcb_rx_port_i (.clk_sys, .arst_n, .clk_en, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rdata, .fifo_octet, .fifo_valid(1'b1), .fifo_ready, .rx_port_clock,
    .rx_read_enable_n, .rx_cell_data_bus, .rx_cell_data_oe, .rx_cell_start_marker,
    .rx_word_parity, .level12_mode, .multi_phy_mode);
  rcb_reader rcb_reader_i (.run, .rx_port_clock, .rx_read_enable_n);
  ////////////////////////////////////////////////////////////////////////////////
  // expectations from the control value
  function automatic logic good(input logic [7:0] c);
    return c[7] && (c[3:2] == RCB_WID_8 ?
      c[1:0] inside {RCB_SIZE_52, RCB_SIZE_53, RCB_SIZE_54} :
      c[3:2] == RCB_WID_16 && c[1:0] inside {RCB_SIZE_52, RCB_SIZE_54});
  endfunction
  function automatic int beats(input logic [7:0] c);
    return (c[1:0] == RCB_SIZE_52 ? 52 : c[1:0] == RCB_SIZE_53 ? 53 : 54) /
      (c[3:2] == RCB_WID_16 ? 2 : 1);
  endfunction
  // odd parity bit expected over the lanes that the width field enables
  function automatic logic par_exp(input logic [15:0] d, input logic [7:0] c);
    return $countones(c[3:2] == RCB_WID_16 ? d : {d[15:8], 8'h00}) % 2 == 0;
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  // one configuration, one burst of reading, then cell counts
  task automatic scen(input logic [4:0] k);
    cur = {k[4], 3'($random(seed)), k[3:0]};
    wr(RCB_CTRL0_ADDR, cur);
    check("ctrl", reg_rdata, cur);
    check("level", level12_mode, cur[7]);
    check("mphy", multi_phy_mode, cur[7] & cur[6]);
    nbeat = 0;
    nsoc = 0;
    armed = 1'b0;
    run = 1'b1;
    repeat (1100) @(negedge clk_sys);
    run = 1'b0;
    repeat (60) @(negedge clk_sys);
    check("cells", good(cur) ? 16'(nsoc >= 2) : 16'(nsoc), good(cur));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // beats taken at the reader's clock; the first rise of a burst is stale
  always @(posedge rx_port_clock) begin
    if (!rx_read_enable_n && armed) begin
      if (rx_cell_start_marker) begin
        if (nbeat != 0) check("beats", 16'(nbeat), 16'(beats(cur)));
        nbeat = 1;
        nsoc++;
      end else if (nbeat != 0) nbeat++;
      if (nbeat != 0 && cur[3:2] == RCB_WID_8) check("low", rx_cell_data_bus[7:0], 0);
      if (cur[1:0] != RCB_SIZE_52 && nbeat == (cur[3:2] == RCB_WID_16 ? 3 : 5))
        check("hec", rx_cell_data_bus[15:8], RCB_HEC_DUMMY);
      if (nbeat != 0) begin
        check("oe", rx_cell_data_oe, {8'hff, {8{cur[3:2] == RCB_WID_16}}});
        check("parity", rx_word_parity, par_exp(rx_cell_data_bus, cur));
      end
      if (cur[1:0] == RCB_SIZE_54 && nbeat == 27 && cur[3:2] == RCB_WID_16)
        check("stuff", rx_cell_data_bus[7:0], RCB_STUFF_OCT);
      if (cur[1:0] == RCB_SIZE_54 && nbeat == 54 && cur[3:2] == RCB_WID_8)
        check("stuff8", rx_cell_data_bus[15:8], RCB_STUFF_OCT);
    end
    armed = !rx_read_enable_n;
  end
  always @(negedge clk_sys) fifo_octet = 8'($random(seed));
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    seed = 32'h2226;
    clk_en = 1'b1;
    {arst_n, reg_wr, run, armed, reg_wdata, fifo_octet} = '0;
    reg_addr = RCB_CTRL0_ADDR;
    repeat (4) @(negedge clk_sys);
    arst_n = 1'b1;
    check("reset", reg_rdata, RCB_CTRL_RESET);
    wr(16'h0504, 8'h8d);
    check("unmapped", reg_rdata, 8'h00);
    reg_addr = RCB_CTRL0_ADDR;
    #1 check("kept", reg_rdata, RCB_CTRL_RESET);
    // a write while the clock enable is low must not land
    clk_en = 1'b0;
    @(negedge clk_sys);
    wr(RCB_CTRL0_ADDR, 8'h94);
    check("frozen", reg_rdata, RCB_CTRL_RESET);
    clk_en = 1'b1;
    @(negedge clk_sys);
    foreach (cfg[i]) scen(cfg[i]);
    test_done();
  end
endmodule // rcb_rx_port_test
`default_nettype wire
